/* design/tma_pkg.sv */
// Constants, register map and types for the tilt mirror actuator servo.
// Assumes a 200 MHz core clock and AXI4-Lite register access.
package tma_pkg;
  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SERVO_RATE_HZ = 70_000;
  localparam int unsigned SERVO_DIV = CLK_HZ / SERVO_RATE_HZ;
  localparam logic [11:0] SERVO_LAST = 12'(SERVO_DIV - 1);
  localparam logic [7:0] SETTLE_CYC = 8'h10;
  // ***********************************************************
  // Channels and memories
  // ***********************************************************
  localparam int NCH = 6;
  localparam int NLOOP = 5;
  localparam int COMMON_CH = 5;
  localparam int NPRM = 11;
  localparam int SEQ_DEPTH = 64;
  localparam logic [8:0] SCALE_FULL = 9'h100;
  localparam logic signed [15:0] UNITY_Q8 = 16'sh0100;
  // Per channel parameter index
  localparam int P_CMD = 0, P_IG = 1, P_IO = 2, P_OG = 3, P_OO = 4;
  localparam int P_KE0 = 5, P_KE1 = 6, P_KE2 = 7, P_KP0 = 8, P_KP1 = 9, P_KP2 = 10;
  // ***********************************************************
  // Register byte offsets
  // ***********************************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_IRQ_STAT = 8'h0C;
  localparam logic [7:0] A_IRQ_MASK = 8'h10;
  localparam logic [7:0] A_CH_SEL = 8'h14;
  localparam logic [7:0] A_COMMON = 8'h18;
  localparam logic [7:0] A_SEQ_CFG = 8'h1C;
  localparam logic [7:0] A_SEQ_ADDR = 8'h20;
  localparam logic [7:0] A_SEQ_DATA = 8'h24;
  localparam logic [7:0] A_DIAG_TOL = 8'h28;
  localparam logic [7:0] A_RAMP_STEP = 8'h2C;
  localparam logic [7:0] A_PRM_BASE = 8'h40;
  // Reset values
  localparam logic [15:0] COMMON_RST = 16'h4000;
  localparam logic [15:0] DIAG_TOL_RST = 16'h0040;
  localparam logic [8:0] RAMP_STEP_RST = 9'h001;
  // Interrupt / event bits
  localparam int EV_PWR_DONE = 0, EV_FAULT = 1, EV_REJECT = 2, EV_SEQ_DONE = 3;
  localparam int NEV = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    S_OFF = 4'h0, S_RELAY_OPEN = 4'h1, S_HV_ON = 4'h2, S_ZERO = 4'h3,
    S_CLOSE = 4'h4, S_CHK_UP = 4'h5, S_RAMP_UP = 4'h6, S_ON = 4'h7,
    S_RAMP_DN = 4'h8, S_CHK_DN = 4'h9, S_OPEN = 4'hA, S_HV_OFF = 4'hB,
    S_FAULT = 4'hC
  } tma_pwr_e;
endpackage : tma_pkg

/* design/tma_servo_top.sv */
// Tilt mirror actuator servo: 70 kHz local position loop, calibration,
// test sequence replay/capture and high voltage power sequencing.
// Assumes synchronous inputs on core_clk_i and an AXI4-Lite master.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tma_servo_top (
  input wire logic core_clk_i,            // 200 MHz clock
  input wire logic rst_b_i,               // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr,    // Write address
  input wire logic s_axi_awvalid,         // Write address valid
  output logic s_axi_awready,             // Write address ready
  input wire logic [31:0] s_axi_wdata,    // Write data
  input wire logic [3:0] s_axi_wstrb,     // Write byte strobes
  input wire logic s_axi_wvalid,          // Write data valid
  output logic s_axi_wready,              // Write data ready
  output logic [1:0] s_axi_bresp,         // Write response
  output logic s_axi_bvalid,              // Write response valid
  input wire logic s_axi_bready,          // Write response ready
  input wire logic [7:0] s_axi_araddr,    // Read address
  input wire logic s_axi_arvalid,         // Read address valid
  output logic s_axi_arready,             // Read address ready
  output logic [31:0] s_axi_rdata,        // Read data
  output logic [1:0] s_axi_rresp,         // Read response
  output logic s_axi_rvalid,              // Read data valid
  input wire logic s_axi_rready,          // Read data ready
  input wire logic [79:0] sg_pos_i,       // Strain gauge positions, 5 x 16
  input wire logic [95:0] hv_mon_i,       // Output monitor readings, 6 x 16
  output logic [95:0] hv_drive_o,         // Driver voltage words, 6 x 16
  output logic hv_supply_en_o,            // High voltage supply enable
  output logic relay_close_o,             // Output relays closed
  output logic irq_o                      // Level interrupt
);
  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic signed [15:0] sat16(input logic signed [25:0] v);
    if (v > 26'sh0007FFF) return 16'sh7FFF;
    if (v < -26'sh0008000) return -16'sh8000;
    return v[15:0];
  endfunction : sat16

  function automatic logic signed [25:0] q8(input logic signed [15:0] a,
                                            input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return 26'(p >>> 8);
  endfunction : q8

  // ***********************************************************
  // State
  // ***********************************************************
  tma_pkg::tma_pwr_e state, next_state;
  logic signed [15:0] prm [tma_pkg::NLOOP][tma_pkg::NPRM];
  logic signed [15:0] e1 [tma_pkg::NLOOP];
  logic signed [15:0] ye1 [tma_pkg::NLOOP];
  logic signed [15:0] p1 [tma_pkg::NLOOP];
  logic signed [15:0] yp1 [tma_pkg::NLOOP];
  logic signed [15:0] outr [tma_pkg::NLOOP];
  logic signed [15:0] rep [tma_pkg::SEQ_DEPTH];
  logic signed [15:0] cap [tma_pkg::SEQ_DEPTH];
  logic [11:0] tcnt;
  logic [2:0] chi;
  logic comp_on;
  logic loop_on;
  logic [2:0] ch_sel;
  logic [15:0] common_v;
  logic [15:0] diag_tol;
  logic [8:0] ramp_step;
  logic [8:0] scale;
  logic [7:0] wcnt;
  logic [5:0] seq_len, seq_idx, seq_addr;
  logic [2:0] seq_ch;
  logic seq_run;
  logic [tma_pkg::NEV-1:0] irq_stat, irq_mask;

  // ***********************************************************
  // AXI4-Lite handshakes
  // ***********************************************************
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd = s_axi_wdata & wmask;
  wire [7:0] wa = s_axi_awaddr;
  wire [7:0] ra = s_axi_araddr;
  wire wa_prm = wa >= tma_pkg::A_PRM_BASE && wa < tma_pkg::A_PRM_BASE + 8'(4 * tma_pkg::NPRM);
  wire ra_prm = ra >= tma_pkg::A_PRM_BASE && ra < tma_pkg::A_PRM_BASE + 8'(4 * tma_pkg::NPRM);
  wire [3:0] wa_idx = 4'((wa - tma_pkg::A_PRM_BASE) >> 2);
  wire [3:0] ra_idx = 4'((ra - tma_pkg::A_PRM_BASE) >> 2);
  wire ch_ok = ch_sel < 3'(tma_pkg::NLOOP);
  wire wa_ok = wa_prm || (wa <= tma_pkg::A_RAMP_STEP && wa[1:0] == 2'h0);
  wire ra_ok = ra_prm || (ra <= tma_pkg::A_RAMP_STEP && ra[1:0] == 2'h0);
  wire wr_ctrl = wr_go && wa == tma_pkg::A_CTRL;
  wire wr_cmd = wr_go && wa == tma_pkg::A_CMD;
  wire rd_irq = rd_go && ra == tma_pkg::A_IRQ_STAT;

  // ***********************************************************
  // Supervisory commands
  // ***********************************************************
  wire busy = !(state == tma_pkg::S_OFF || state == tma_pkg::S_ON ||
                state == tma_pkg::S_FAULT);
  wire powered = state == tma_pkg::S_ON;
  wire req_up = wr_cmd && wd[0];
  wire req_dn = wr_cmd && wd[1];
  wire req_seq = wr_cmd && wd[2];
  wire req_loop = wr_ctrl && wd[0];
  // Loop close only once powered and idle; opening always accepted
  wire loop_ok = powered && !busy;
  wire up_ok = state == tma_pkg::S_OFF;
  wire dn_ok = (state == tma_pkg::S_ON && !loop_on && !req_loop) ||
               state == tma_pkg::S_FAULT;
  wire seq_ok = !busy && !seq_run;
  wire reject = (req_loop && !loop_ok) || (req_up && !up_ok) ||
                (req_dn && !dn_ok) || (req_seq && !seq_ok);

  // ***********************************************************
  // Power sequencing
  // ***********************************************************
  wire settled = wcnt == tma_pkg::SETTLE_CYC;
  logic diag_zero;
  always_comb begin
    diag_zero = 1'b1;
    for (int k = 0; k < tma_pkg::NCH; k++) begin
      if ($signed(hv_mon_i[k*16 +: 16]) > $signed(diag_tol) ||
          $signed(hv_mon_i[k*16 +: 16]) < -$signed(diag_tol)) begin
        diag_zero = 1'b0;
      end
    end
  end
  wire tick = tcnt == tma_pkg::SERVO_LAST;
  wire top_hit = scale >= tma_pkg::SCALE_FULL - ramp_step;
  wire bot_hit = scale <= ramp_step;

  always_comb begin
    next_state = state;
    case (state)
      tma_pkg::S_OFF: if (req_up && up_ok) next_state = tma_pkg::S_RELAY_OPEN;
      tma_pkg::S_RELAY_OPEN: if (settled) next_state = tma_pkg::S_HV_ON;
      tma_pkg::S_HV_ON: if (settled) next_state = tma_pkg::S_ZERO;
      tma_pkg::S_ZERO: if (settled) next_state = tma_pkg::S_CLOSE;
      tma_pkg::S_CLOSE: if (settled) next_state = tma_pkg::S_CHK_UP;
      tma_pkg::S_CHK_UP: begin
        if (settled) next_state = diag_zero ? tma_pkg::S_RAMP_UP : tma_pkg::S_FAULT;
      end
      tma_pkg::S_RAMP_UP: if (tick && top_hit) next_state = tma_pkg::S_ON;
      tma_pkg::S_ON: if (req_dn && dn_ok) next_state = tma_pkg::S_RAMP_DN;
      tma_pkg::S_RAMP_DN: if (tick && bot_hit) next_state = tma_pkg::S_CHK_DN;
      tma_pkg::S_CHK_DN: begin
        if (settled) next_state = diag_zero ? tma_pkg::S_OPEN : tma_pkg::S_FAULT;
      end
      tma_pkg::S_OPEN: if (settled) next_state = tma_pkg::S_HV_OFF;
      tma_pkg::S_HV_OFF: if (settled) next_state = tma_pkg::S_OFF;
      tma_pkg::S_FAULT: if (req_dn) next_state = tma_pkg::S_OFF;
      default: next_state = tma_pkg::S_OFF;
    endcase
  end

  wire pwr_done = (state == tma_pkg::S_RAMP_UP && next_state == tma_pkg::S_ON) ||
                  (state == tma_pkg::S_HV_OFF && next_state == tma_pkg::S_OFF);
  wire fault_ev = next_state == tma_pkg::S_FAULT && state != tma_pkg::S_FAULT;
  wire relay_next = state == tma_pkg::S_CLOSE || state == tma_pkg::S_CHK_UP ||
                    state == tma_pkg::S_RAMP_UP || state == tma_pkg::S_ON ||
                    state == tma_pkg::S_RAMP_DN || state == tma_pkg::S_CHK_DN;
  wire hv_next = !(state == tma_pkg::S_OFF || state == tma_pkg::S_RELAY_OPEN ||
                   state == tma_pkg::S_FAULT);
  wire live = state == tma_pkg::S_RAMP_UP || state == tma_pkg::S_ON ||
              state == tma_pkg::S_RAMP_DN;

  // ***********************************************************
  // Servo datapath, one loop channel per cycle after each tick
  // ***********************************************************
  wire seq_hit = seq_run && seq_ch == chi;
  wire signed [15:0] sg_c = $signed(sg_pos_i[chi*16 +: 16]);
  wire signed [15:0] pos_c = sat16(q8(sg_c, prm[chi][tma_pkg::P_IG]) +
                                   26'(prm[chi][tma_pkg::P_IO]));
  wire signed [15:0] cmd_c = sat16(26'(prm[chi][tma_pkg::P_CMD]) +
                                   26'(seq_hit ? rep[seq_idx] : 16'sh0000));
  wire signed [15:0] err_c = sat16(26'(cmd_c) - 26'(pos_c));
  wire signed [15:0] ye_c = sat16(q8(prm[chi][tma_pkg::P_KE0], err_c) +
                                  q8(prm[chi][tma_pkg::P_KE1], e1[chi]) +
                                  q8(prm[chi][tma_pkg::P_KE2], ye1[chi]));
  wire signed [15:0] yp_c = sat16(q8(prm[chi][tma_pkg::P_KP0], pos_c) +
                                  q8(prm[chi][tma_pkg::P_KP1], p1[chi]) +
                                  q8(prm[chi][tma_pkg::P_KP2], yp1[chi]));
  wire signed [15:0] u_c = sat16(26'(ye_c) + 26'(yp_c));
  wire signed [15:0] o_c = sat16(q8(u_c, prm[chi][tma_pkg::P_OG]) +
                                 26'(prm[chi][tma_pkg::P_OO]));
  wire signed [15:0] raw_c = loop_on ? o_c : cmd_c;
  wire signed [15:0] sc_q8 = $signed({7'h00, scale});
  wire seq_end = seq_hit && comp_on && seq_idx == seq_len;

  // ***********************************************************
  // Clocked state
  // ***********************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state <= tma_pkg::S_OFF;
      tcnt <= 12'h000;
      chi <= 3'h0;
      comp_on <= 1'b0;
      loop_on <= 1'b0;
      wcnt <= 8'h00;
      scale <= 9'h000;
      seq_run <= 1'b0;
      seq_idx <= 6'h00;
      relay_close_o <= 1'b0;
      hv_supply_en_o <= 1'b0;
      hv_drive_o <= 96'h0;
      irq_stat <= '0;
      for (int k = 0; k < tma_pkg::NLOOP; k++) begin
        e1[k] <= 16'sh0000;
        ye1[k] <= 16'sh0000;
        p1[k] <= 16'sh0000;
        yp1[k] <= 16'sh0000;
        outr[k] <= 16'sh0000;
      end
    end else begin
      state <= next_state;
      wcnt <= (next_state != state || settled) ? 8'h00 : wcnt + 8'h01;
      tcnt <= tick ? 12'h000 : tcnt + 12'h001;
      if (tick) begin
        comp_on <= 1'b1;
        chi <= 3'h0;
      end else if (comp_on) begin
        chi <= chi + 3'h1;
        if (chi == 3'(tma_pkg::NLOOP - 1)) comp_on <= 1'b0;
      end
      if (comp_on) begin
        e1[chi] <= err_c;
        ye1[chi] <= ye_c;
        p1[chi] <= pos_c;
        yp1[chi] <= yp_c;
        outr[chi] <= raw_c;
      end
      if (req_loop && loop_ok) loop_on <= 1'b1;
      else if (wr_ctrl && !wd[0]) loop_on <= 1'b0;
      if (state == tma_pkg::S_RAMP_UP && tick) begin
        scale <= top_hit ? tma_pkg::SCALE_FULL : scale + ramp_step;
      end else if (state == tma_pkg::S_RAMP_DN && tick) begin
        scale <= bot_hit ? 9'h000 : scale - ramp_step;
      end else if (!live) begin
        scale <= 9'h000;
      end
      if (req_seq && seq_ok) begin
        seq_run <= 1'b1;
        seq_idx <= 6'h00;
      end else if (seq_hit && comp_on) begin
        cap[seq_idx] <= pos_c;
        seq_idx <= seq_idx + 6'h01;
        if (seq_end) seq_run <= 1'b0;
      end
      relay_close_o <= relay_next;
      hv_supply_en_o <= hv_next;
      for (int k = 0; k < tma_pkg::NLOOP; k++) begin
        hv_drive_o[k*16 +: 16] <= live ? sat16(q8(outr[k], sc_q8)) : 16'h0000;
      end
      if (state == tma_pkg::S_ON) begin
        hv_drive_o[tma_pkg::COMMON_CH*16 +: 16] <= common_v;
      end else if (live) begin
        hv_drive_o[tma_pkg::COMMON_CH*16 +: 16] <=
          sat16(26'(q8(outr[3], sc_q8)) <<< 1);
      end else begin
        hv_drive_o[tma_pkg::COMMON_CH*16 +: 16] <= 16'h0000;
      end
      irq_stat <= (rd_irq ? '0 : irq_stat) |
                  {seq_end, reject, fault_ev, pwr_done};
    end
  end

  // ***********************************************************
  // Register file writes
  // ***********************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ch_sel <= 3'h0;
      common_v <= tma_pkg::COMMON_RST;
      diag_tol <= tma_pkg::DIAG_TOL_RST;
      ramp_step <= tma_pkg::RAMP_STEP_RST;
      seq_len <= 6'h00;
      seq_ch <= 3'h0;
      seq_addr <= 6'h00;
      irq_mask <= '0;
      for (int k = 0; k < tma_pkg::NLOOP; k++) begin
        for (int j = 0; j < tma_pkg::NPRM; j++) begin
          prm[k][j] <= (j == tma_pkg::P_IG || j == tma_pkg::P_OG) ?
                       tma_pkg::UNITY_Q8 : 16'sh0000;
        end
      end
    end else if (wr_go) begin
      case (wa)
        tma_pkg::A_CH_SEL: ch_sel <= wd[2:0];
        tma_pkg::A_COMMON: common_v <= wd[15:0];
        tma_pkg::A_DIAG_TOL: diag_tol <= wd[15:0];
        tma_pkg::A_RAMP_STEP: ramp_step <= wd[8:0];
        tma_pkg::A_IRQ_MASK: irq_mask <= wd[tma_pkg::NEV-1:0];
        tma_pkg::A_SEQ_ADDR: seq_addr <= wd[5:0];
        tma_pkg::A_SEQ_CFG: begin
          if (!seq_run) begin
            seq_len <= wd[5:0];
            seq_ch <= wd[10:8];
          end
        end
        tma_pkg::A_SEQ_DATA: begin
          rep[seq_addr] <= wd[15:0];
          seq_addr <= seq_addr + 6'h01;
        end
        default: begin
          if (wa_prm && ch_ok) prm[ch_sel][wa_idx] <= wd[15:0];
        end
      endcase
    end
  end

  // ***********************************************************
  // Read path and responses
  // ***********************************************************
  wire [31:0] status_w = {23'h0, seq_run, state == tma_pkg::S_FAULT, loop_on,
                          powered, busy, 4'(state)};
  logic [31:0] rd_mux;
  always_comb begin
    case (ra)
      tma_pkg::A_CTRL: rd_mux = {31'h0, loop_on};
      tma_pkg::A_STATUS: rd_mux = status_w;
      tma_pkg::A_IRQ_STAT: rd_mux = 32'(irq_stat);
      tma_pkg::A_IRQ_MASK: rd_mux = 32'(irq_mask);
      tma_pkg::A_CH_SEL: rd_mux = 32'(ch_sel);
      tma_pkg::A_COMMON: rd_mux = 32'(common_v);
      tma_pkg::A_SEQ_CFG: rd_mux = {21'h0, seq_ch, 2'h0, seq_len};
      tma_pkg::A_SEQ_ADDR: rd_mux = 32'(seq_addr);
      tma_pkg::A_SEQ_DATA: rd_mux = 32'(cap[seq_addr]);
      tma_pkg::A_DIAG_TOL: rd_mux = 32'(diag_tol);
      tma_pkg::A_RAMP_STEP: rd_mux = 32'(ramp_step);
      default: rd_mux = (ra_prm && ch_ok) ? 32'(prm[ch_sel][ra_idx]) : 32'h0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tma_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= tma_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0;
      irq_o <= 1'b0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? tma_pkg::RESP_OKAY : tma_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= ra_ok ? rd_mux : 32'h0;
        s_axi_rresp <= ra_ok ? tma_pkg::RESP_OKAY : tma_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end
endmodule : tma_servo_top

/* dv/tma_chk.sv */
// Checker for the servo block: bus answers and output power order.
// Bound to every instance of the servo top module.
`timescale 1ns/1ps
module tma_chk (
  input wire logic core_clk_i,        // Core clock
  input wire logic rst_b_i,           // Reset, active low
  input wire logic s_axi_awvalid,     // Write address valid
  input wire logic s_axi_wvalid,      // Write data valid
  input wire logic s_axi_bvalid,      // Write response valid
  input wire logic s_axi_bready,      // Write response ready
  input wire logic s_axi_arvalid,     // Read address valid
  input wire logic s_axi_rvalid,      // Read data valid
  input wire logic s_axi_rready,      // Read data ready
  input wire logic [95:0] hv_drive_o, // Driver words
  input wire logic hv_supply_en_o,    // Supply enable
  input wire logic relay_close_o      // Relays closed
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_relay_hv: assert property (relay_close_o |-> hv_supply_en_o)
    else $error("relays closed while supply off");
  a_close_zero: assert property ($rose(relay_close_o) |-> hv_drive_o == 96'h0)
    else $error("relays closed with nonzero drive");
  a_drive_path: assert property (hv_drive_o != 96'h0 |-> relay_close_o)
    else $error("drive applied with relays open");
  a_close_late: assert property ($rose(relay_close_o) |-> $past(hv_supply_en_o, 30))
    else $error("relays closed too soon after supply on");
  a_supply_last: assert property ($fell(hv_supply_en_o) |->
    !relay_close_o && hv_drive_o == 96'h0) else $error("supply off before outputs safe");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held");
  a_rd_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held");
  c_power_up: cover property ($rose(relay_close_o));
  c_power_down: cover property ($fell(relay_close_o) && hv_supply_en_o);
  c_supply_off: cover property ($fell(hv_supply_en_o));
endmodule : tma_chk

bind tma_servo_top tma_chk u_chk (.*);

/* dv/tma_hv_model.sv */
// Model of the drivers, output monitors and strain gauges.
// Assumes driver words on the core clock; flt_i offsets every monitor.
`timescale 1ns/1ps
module tma_hv_model (
  input wire logic clk_i,          // Core clock
  input wire logic [95:0] drive_i, // Driver words
  input wire logic supply_i,       // Supply on
  input wire logic relay_i,        // Relays closed
  input wire logic flt_i,          // Inject monitor error
  output logic [95:0] mon_o,       // Monitor readings
  output logic [79:0] pos_o        // Gauge positions
);
  always @(posedge clk_i) begin
    for (int k = 0; k < 6; k++) begin
      mon_o[16*k +: 16] <= supply_i ? drive_i[16*k +: 16] + (flt_i ? 16'h0200 : 16'h0) : 16'h0;
    end
    pos_o <= relay_i ? drive_i[79:0] : 80'h0;
  end
endmodule : tma_hv_model

/* dv/test_tilt_mirror_actuator_servo.sv */
// Self-checking bench for the servo block, driven over AXI4-Lite.
// Assumes the driver model and the checker bound to the top module.
`timescale 1ns/1ps
module test_tilt_mirror_actuator_servo;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d, cmd, smp;
  logic [95:0] hv_mon_i, hv_drive_o, prev;
  logic [79:0] sg_pos_i;
  logic hv_supply_en_o, relay_close_o, irq_o;
  logic flt = 1'b0;
  int failures = 0;
  int samples_checked = 0;
  int ramp_seen = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  tma_servo_top uut (.*);
  tma_hv_model u_hv (.clk_i(core_clk_i), .drive_i(hv_drive_o), .supply_i(hv_supply_en_o),
    .relay_i(relay_close_o), .flt_i(flt), .mon_o(hv_mon_i), .pos_o(sg_pos_i));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH time=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk_i);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(d, e);
    cmp({30'h0, r}, 32'h0);
  endtask : rdc
  task automatic wst(input logic [3:0] s);
    rd(tma_pkg::A_STATUS);
    for (int i = 0; i < 9000 && d[3:0] !== s; i++) rd(tma_pkg::A_STATUS);
    cmp({28'h0, d[3:0]}, {28'h0, s});
  endtask : wst
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // Common channel must track twice the scaled tilt channel while ramping
  always @(posedge core_clk_i) begin
    prev <= hv_drive_o;
    if (prev === hv_drive_o && hv_drive_o[95:80] !== 16'h0 &&
        hv_drive_o[95:80] !== tma_pkg::COMMON_RST) begin
      ramp_seen++;
      cmp({16'h0, hv_drive_o[95:80]}, {15'h0, hv_drive_o[63:48], 1'b0});
    end
  end
  initial begin
    repeat (90000) @(posedge core_clk_i);
    failures++;
    test_done();
  end
  // ***********************************************************
  // Stimulus
  // ***********************************************************
  initial begin
    void'($urandom(32'hE446));
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    rdc(tma_pkg::A_STATUS, 32'h0);
    rdc(tma_pkg::A_COMMON, 32'h4000);
    rdc(tma_pkg::A_PRM_BASE + 8'h04, 32'h100);
    rdc(tma_pkg::A_PRM_BASE + 8'h0C, 32'h100);
    rd(8'h3C);
    cmp({30'h0, r}, 32'h2);
    wr(8'h3C, 32'h1);
    cmp({30'h0, r}, 32'h2);
    s_axi_wstrb <= 4'h1;
    wr(tma_pkg::A_DIAG_TOL, 32'h1234);
    s_axi_wstrb <= 4'hF;
    rdc(tma_pkg::A_DIAG_TOL, 32'h34);
    wr(tma_pkg::A_DIAG_TOL, 32'h40);
    wr(tma_pkg::A_CTRL, 32'h1);
    cmp({31'h0, irq_o}, 32'h0);
    wr(tma_pkg::A_IRQ_MASK, 32'hF);
    cmp({31'h0, irq_o}, 32'h1);
    rdc(tma_pkg::A_IRQ_STAT, 32'h4);
    rdc(tma_pkg::A_STATUS, 32'h0);
    cmp({31'h0, irq_o}, 32'h0);
    cmd = $urandom_range(32'h3FF, 32'h100);
    wr(tma_pkg::A_CH_SEL, 32'h3);
    wr(tma_pkg::A_PRM_BASE, cmd);
    wr(tma_pkg::A_RAMP_STEP, 32'h40);
    wr(tma_pkg::A_CMD, 32'h1);
    rd(tma_pkg::A_STATUS);
    cmp({31'h0, d[4]}, 32'h1);
    wr(tma_pkg::A_CMD, 32'h1);
    wst(4'h7);
    repeat (3000) @(posedge core_clk_i);
    cmp({16'h0, hv_drive_o[63:48]}, cmd);
    cmp({16'h0, hv_drive_o[95:80]}, 32'h4000);
    // Two sample replay on channel 3, capture read back
    smp = $urandom_range(32'hFF, 32'h1);
    wr(tma_pkg::A_SEQ_CFG, 32'h301);
    wr(tma_pkg::A_SEQ_ADDR, 32'h0);
    wr(tma_pkg::A_SEQ_DATA, smp);
    wr(tma_pkg::A_SEQ_DATA, 32'h0);
    wr(tma_pkg::A_CMD, 32'h4);
    do rd(tma_pkg::A_STATUS); while (d[8] === 1'b1);
    wr(tma_pkg::A_SEQ_ADDR, 32'h0);
    rdc(tma_pkg::A_SEQ_DATA, cmd);
    wr(tma_pkg::A_SEQ_ADDR, 32'h1);
    rdc(tma_pkg::A_SEQ_DATA, cmd + smp);
    rdc(tma_pkg::A_IRQ_STAT, 32'hD);
    // Closed loop with zero taps must settle on the output offset
    smp = $urandom_range(32'hFF, 32'h10);
    wr(tma_pkg::A_PRM_BASE + 8'h10, smp);
    wr(tma_pkg::A_CTRL, 32'h1);
    rdc(tma_pkg::A_STATUS, 32'h67);
    wr(tma_pkg::A_CMD, 32'h2);
    rdc(tma_pkg::A_STATUS, 32'h67);
    repeat (3000) @(posedge core_clk_i);
    cmp({16'h0, hv_drive_o[63:48]}, smp);
    wr(tma_pkg::A_CTRL, 32'h0);
    wr(tma_pkg::A_CMD, 32'h2);
    wst(4'h0);
    cmp({30'h0, relay_close_o, hv_supply_en_o}, 32'h0);
    cmp({31'h0, ramp_seen > 0}, 32'h1);
    flt <= 1'b1;
    wr(tma_pkg::A_CMD, 32'h1);
    wst(4'hC);
    cmp({30'h0, relay_close_o, hv_supply_en_o}, 32'h0);
    rdc(tma_pkg::A_IRQ_STAT, 32'h7);
    flt <= 1'b0;
    wr(tma_pkg::A_CMD, 32'h2);
    wst(4'h0);
    test_done();
  end
endmodule : test_tilt_mirror_actuator_servo
